// >>> hw/uarx_baud.sv
// Baud-rate generator giving a one-cycle pulse at sixteen times the bit rate.
`timescale 1ns/1ps
module uarx_baud (
    input  wire logic       clock,
    input  wire logic       rstN,
    input  wire logic       enable,
    input  wire logic [3:0] baudSelectCode,
    output logic            tick16
);
    import uarx_pkg::*;

    typedef struct packed {
        logic [8:0] cnt;
        logic       tick;
    } uarx_baud_s;

    uarx_baud_s b_q;
    uarx_baud_s b_d;
    logic [8:0] baudDivisor;

    always_comb begin
        baudDivisor = (baudSelectCode[3] ? BAUD_TRIPLE : BAUD_SINGLE) << baudSelectCode[2:0];
        b_d         = b_q;
        b_d.tick    = 1'b0;
        if (!enable) begin
            b_d.cnt = 9'h000;
        end else if (b_q.cnt >= baudDivisor - 9'h001) begin
            b_d.cnt  = 9'h000;
            b_d.tick = 1'b1;
        end else begin
            b_d.cnt = b_q.cnt + 9'h001;
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            b_q <= '0;
        end else begin
            b_q <= b_d;
        end
    end

    assign tick16 = b_q.tick;

    property p_baud_div;
        @(posedge clock) disable iff (!rstN)
        (tick16 && enable && baudSelectCode == 4'h8) ##1 (enable && baudSelectCode == 4'h8)[*2]
            |-> ##1 tick16;
    endproperty
    a_baud_div: assert property (p_baud_div) else $error("baud period wrong for code 8");

endmodule : uarx_baud

// >>> hw/uarx_pkg.sv
// Shared constants and types of the receive readout, baud and interrupt block.
package uarx_pkg;

    // ==========================================================
    // Serial command and readout words
    localparam logic [1:0] CMD_READ_DATA  = 2'h0;
    localparam logic [1:0] CMD_WRITE_DATA = 2'h2;
    localparam logic [4:0] LAST_EDGE      = 5'h0f;
    localparam logic [4:0] WORD_EDGES     = 5'h10;
    localparam int unsigned BIT_READY      = 15;
    localparam int unsigned BIT_TXEMPTY    = 14;
    localparam int unsigned BIT_ACT_FE     = 10;
    localparam int unsigned BIT_CTS        = 9;
    localparam int unsigned BIT_PARITY     = 8;
    localparam int unsigned BIT_TX_DISABLE = 10;
    localparam int unsigned BIT_RTS        = 9;

    // ==========================================================
    // Baud generator, character timing, receive queue and pin reset values
    localparam logic [8:0] BAUD_SINGLE = 9'h001;
    localparam logic [8:0] BAUD_TRIPLE = 9'h003;
    localparam logic [3:0] SAMPLE_MID  = 4'h7;
    localparam logic [3:0] SAMPLE_LAST = 4'hf;
    localparam logic [3:0] LONG_LAST   = 4'h7;
    localparam logic [3:0] SHORT_LAST  = 4'h6;
    localparam logic [3:0] FRAME_BITS  = 4'ha;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [3:0] FIFO_FULL   = 4'h8;
    localparam logic [4:0] PINS_RESET  = 5'h13;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} uarx_rx_e;

    typedef struct packed {
        logic       parity;
        logic [7:0] data;
    } uarx_char_s;

    typedef struct packed {
        logic csN;
        logic sclk;
        logic din;
        logic rx;
        logic ctsN;
    } uarx_pins_s;

    typedef struct packed {
        logic       parityEnable;
        logic       shortWord;
        logic       availIrqMask;
        logic       parityIrqMask;
        logic       actIrqMask;
        logic       txemptyIrqMask;
        logic       shutdown;
        logic [3:0] baudSelectCode;
    } uarx_cfg_s;

    typedef struct packed {
        logic                        csPrev;
        logic                        sclkPrev;
        logic [4:0]                  edgeCnt;
        logic [15:0]                 shiftIn;
        logic [15:0]                 shiftOut;
        logic                        popPending;
        logic                        dout;
        logic                        irqN;
        logic                        tx;
        logic                        rtsN;
        uarx_char_s [FIFO_DEPTH-1:0] fifo;
        logic [2:0]                  wrPtr;
        logic [2:0]                  rdPtr;
        logic [3:0]                  count;
        uarx_rx_e                    rxState;
        logic [3:0]                  rxPhase;
        logic [3:0]                  rxIdx;
        logic [7:0]                  rxShift;
        logic                        rxPar;
        logic                        frameErr;
        logic                        rxActivity;
        logic                        rxPrev;
        logic                        shutPrev;
        logic                        txFull;
        uarx_char_s                  txBuf;
        logic [10:0]                 txShift;
        logic [3:0]                  txLeft;
        logic [3:0]                  txPhase;
        logic                        txSrc;
    } uarx_core_s;

    localparam uarx_core_s CORE_RESET = '{csPrev: 1'b1, irqN: 1'b1, tx: 1'b1, rtsN: 1'b1,
        rxPrev: 1'b1, txShift: 11'h7ff, rxState: RX_IDLE, default: '0};

endpackage : uarx_pkg

// >>> hw/uarx_readout.sv
// Serial readout word, receiver, transmit buffer and interrupt logic of the UART.
`timescale 1ns/1ps
// ==========================================================
module uarx_readout (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                csN,
    input  wire logic                sclk,
    input  wire logic                din,
    input  wire logic                rxPin,
    input  wire logic                ctsN,
    input  wire uarx_pkg::uarx_cfg_s cfg,
    output logic                     dout,
    output logic                     irqN,
    output logic                     txPin,
    output logic                     rtsN
);
    import uarx_pkg::*;

    // ==========================================================
    // Reset release and input synchronisation
    logic [1:0] rstSync_q;
    logic       rstN;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    uarx_pins_s pins;
    logic       tick16;

    uarx_sync #(.W(5), .RST(PINS_RESET)) u_sync (
        .clock  (clock),
        .rstN   (rstN),
        .raw    ({csN, sclk, din, rxPin, ctsN}),
        .stable (pins)
    );

    uarx_baud u_baud (
        .clock          (clock),
        .rstN           (rstN),
        .enable         (!cfg.shutdown),
        .baudSelectCode (cfg.baudSelectCode),
        .tick16         (tick16)
    );

    // ==========================================================
    // State update
    uarx_core_s  r_q;
    uarx_core_s  r_d;
    uarx_char_s  head;
    uarx_char_s  rxChar;
    logic [15:0] readout;
    logic [15:0] rxWord;
    logic [10:0] frame;
    logic [3:0]  dataLast;
    logic        txParBit;
    logic        ready;
    logic        csFall;
    logic        sclkRise;
    logic        sclkFall;
    logic        rise16;
    logic        fall16;
    logic        dataOp;
    logic        push;
    logic        pop;
    logic        txLoad;

    always_comb begin
        r_d      = r_q;
        head     = r_q.fifo[r_q.rdPtr];
        ready    = (r_q.count != 4'h0);
        readout  = 16'h0000;
        readout[BIT_READY]   = ready;
        readout[BIT_TXEMPTY] = !r_q.txFull;
        readout[BIT_ACT_FE]  = cfg.shutdown ? r_q.rxActivity : r_q.frameErr;
        readout[BIT_CTS]     = !pins.ctsN;
        readout[BIT_PARITY]  = cfg.parityEnable && ready && head.parity;
        readout[7:0]         = ready ? head.data : 8'h00;
        if (cfg.shortWord) begin
            readout[7] = 1'b0;
        end

        // Serial port: bits leave on falling edges, arrive on rising edges.
        csFall   = r_q.csPrev && !pins.csN;
        sclkRise = !pins.csN && !r_q.sclkPrev && pins.sclk;
        sclkFall = !pins.csN && r_q.sclkPrev && !pins.sclk;
        rxWord   = {r_q.shiftIn[14:0], pins.din};
        rise16   = sclkRise && (r_q.edgeCnt == LAST_EDGE);
        fall16   = sclkFall && (r_q.edgeCnt == WORD_EDGES);
        dataOp   = (rxWord[15:14] == CMD_READ_DATA) || (rxWord[15:14] == CMD_WRITE_DATA);
        pop      = fall16 && r_q.popPending && !r_q.shiftIn[14] && ready;
        r_d.csPrev   = pins.csN;
        r_d.sclkPrev = pins.sclk;
        if (csFall) begin
            r_d.shiftOut   = readout;
            r_d.edgeCnt    = 5'h00;
            r_d.popPending = ready;
            r_d.dout       = readout[BIT_READY];
        end
        if (sclkRise) begin
            r_d.shiftIn = rxWord;
            if (r_q.edgeCnt != WORD_EDGES) begin
                r_d.edgeCnt = r_q.edgeCnt + 5'h01;
            end
        end
        if (sclkFall) begin
            r_d.shiftOut = {r_q.shiftOut[14:0], 1'b0};
            r_d.dout     = r_q.shiftOut[14];
        end
        if (pins.csN) begin
            r_d.dout = 1'b0;
        end
        if (rise16 && (rxWord[15:14] == CMD_WRITE_DATA)) begin
            r_d.rtsN = !rxWord[BIT_RTS];
            if (!rxWord[BIT_TX_DISABLE] && !r_q.txFull) begin
                r_d.txFull = 1'b1;
                r_d.txBuf  = '{parity: rxWord[BIT_PARITY], data: rxWord[7:0]};
            end
        end

        // Receiver, sampling each bit in its middle at the 16x rate.
        push     = 1'b0;
        dataLast = cfg.shortWord ? SHORT_LAST : LONG_LAST;
        rxChar   = '{parity: cfg.parityEnable && r_q.rxPar,
                     data: cfg.shortWord ? {1'b0, r_q.rxShift[7:1]} : r_q.rxShift};
        r_d.rxPrev   = pins.rx;
        r_d.shutPrev = cfg.shutdown;
        if (tick16) begin
            r_d.rxPhase = r_q.rxPhase + 4'h1;
            case (r_q.rxState)
                RX_IDLE: begin
                    r_d.rxPhase = 4'h0;
                    if (!pins.rx) begin
                        r_d.rxState = RX_START;
                    end
                end
                RX_START: begin
                    if (r_q.rxPhase == SAMPLE_MID) begin
                        r_d.rxPhase = 4'h0;
                        r_d.rxIdx   = 4'h0;
                        r_d.rxState = pins.rx ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (r_q.rxPhase == SAMPLE_LAST) begin
                        r_d.rxShift = {pins.rx, r_q.rxShift[7:1]};
                        r_d.rxIdx   = r_q.rxIdx + 4'h1;
                        if (r_q.rxIdx == dataLast) begin
                            r_d.rxState = cfg.parityEnable ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY: begin
                    if (r_q.rxPhase == SAMPLE_LAST) begin
                        r_d.rxPar   = pins.rx;
                        r_d.rxState = RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (r_q.rxPhase == SAMPLE_LAST) begin
                        r_d.frameErr = !pins.rx;
                        push         = 1'b1;
                        r_d.rxState  = RX_IDLE;
                    end
                end
                default: begin
                    r_d.rxState = RX_IDLE;
                end
            endcase
        end

        // Receive queue; an overflow discards every stored word.
        if (push && (r_q.count == FIFO_FULL) && !pop) begin
            r_d.rdPtr = r_q.wrPtr;
            r_d.count = 4'h0;
        end else begin
            if (push) begin
                r_d.fifo[r_q.wrPtr] = rxChar;
                r_d.wrPtr           = r_q.wrPtr + 3'h1;
            end
            if (pop) begin
                r_d.rdPtr = r_q.rdPtr + 3'h1;
            end
            r_d.count = r_q.count + {3'h0, push} - {3'h0, pop};
        end

        // Transmitter: start, data LSB first, optional parity, one stop bit.
        txLoad   = 1'b0;
        txParBit = cfg.parityEnable ? r_q.txBuf.parity : 1'b1;
        frame    = cfg.shortWord ? {2'h3, txParBit, r_q.txBuf.data[6:0], 1'b0}
                                 : {1'b1, txParBit, r_q.txBuf.data, 1'b0};
        if (tick16) begin
            if (r_q.txLeft == 4'h0) begin
                if (r_q.txFull) begin
                    txLoad      = 1'b1;
                    r_d.txFull  = 1'b0;
                    r_d.txShift = frame;
                    r_d.tx      = frame[0];
                    r_d.txPhase = 4'h0;
                    r_d.txLeft  = FRAME_BITS - {3'h0, cfg.shortWord} + {3'h0, cfg.parityEnable};
                end
            end else begin
                r_d.txPhase = r_q.txPhase + 4'h1;
                if (r_q.txPhase == SAMPLE_LAST) begin
                    r_d.txShift = {1'b1, r_q.txShift[10:1]};
                    r_d.txLeft  = r_q.txLeft - 4'h1;
                    r_d.tx      = r_q.txShift[1];
                end
            end
        end
        if (rise16 && dataOp) begin
            r_d.txSrc = 1'b0;
        end
        if (txLoad) begin
            r_d.txSrc = 1'b1;
        end

        // Shutdown empties the receive side and the transmit buffer.
        if (cfg.shutdown) begin
            r_d.count      = 4'h0;
            r_d.rdPtr      = r_d.wrPtr;
            r_d.popPending = 1'b0;
            r_d.frameErr   = 1'b0;
            r_d.rxState    = RX_IDLE;
            r_d.txFull     = 1'b0;
            r_d.txLeft     = 4'h0;
            r_d.txShift    = 11'h7ff;
            r_d.tx         = 1'b1;
            if (!r_q.shutPrev) begin
                r_d.rxActivity = 1'b0;
            end else if (pins.rx != r_q.rxPrev) begin
                r_d.rxActivity = 1'b1;
            end
        end else begin
            r_d.rxActivity = 1'b0;
        end

        // Interrupt follows live sources, so a transaction releases it once they clear.
        r_d.irqN = !((ready && cfg.availIrqMask)
                  || (readout[BIT_PARITY] && cfg.parityIrqMask)
                  || (readout[BIT_ACT_FE] && cfg.actIrqMask)
                  || (r_q.txSrc && cfg.txemptyIrqMask));
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            r_q <= CORE_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    assign dout  = r_q.dout;
    assign irqN  = r_q.irqN;
    assign txPin = r_q.tx;
    assign rtsN  = r_q.rtsN;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstN);

    property p_ready_bit;
        csFall |=> r_q.shiftOut[15] == $past(ready);
    endproperty
    a_ready_bit: assert property (p_ready_bit) else $error("ready bit wrong");

    property p_txempty_bit;
        csFall |=> (r_q.shiftOut[14] == !$past(r_q.txFull)) && (r_q.shiftOut[13:11] == 3'h0);
    endproperty
    a_txempty_bit: assert property (p_txempty_bit) else $error("empty bit wrong");

    property p_cts_bit;
        csFall |=> r_q.shiftOut[9] == !$past(pins.ctsN);
    endproperty
    a_cts_bit: assert property (p_cts_bit) else $error("handshake bit wrong");

    property p_parity_off;
        csFall && !cfg.parityEnable |=> !r_q.shiftOut[8];
    endproperty
    a_parity_off: assert property (p_parity_off) else $error("parity bit set");

    property p_short_word;
        csFall && cfg.shortWord |=> !r_q.shiftOut[7];
    endproperty
    a_short_word: assert property (p_short_word) else $error("bit 7 set");

    property p_last_pop;
        fall16 && r_q.popPending && !r_q.shiftIn[14] && (r_q.count == 4'h1) && !push
            |=> (r_q.count == 4'h0) ##1 (r_q.irqN
                || (cfg.txemptyIrqMask && $past(r_q.txSrc))
                || (cfg.actIrqMask && $past(readout[BIT_ACT_FE])));
    endproperty
    a_last_pop: assert property (p_last_pop) else $error("ready not dropped");

    property p_txsrc_clear;
        rise16 && dataOp && !txLoad |=> !r_q.txSrc;
    endproperty
    a_txsrc_clear: assert property (p_txsrc_clear) else $error("tx source not cleared");

    property p_avail_irq;
        ready && cfg.availIrqMask |=> !irqN;
    endproperty
    a_avail_irq: assert property (p_avail_irq) else $error("irq not asserted");

    property p_frame_err;
        tick16 && (r_q.rxState == RX_STOP) && (r_q.rxPhase == SAMPLE_LAST) && !pins.rx
            && !cfg.shutdown |=> r_q.frameErr;
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("framing error missed");

    property p_activity;
        cfg.shutdown && r_q.shutPrev && (pins.rx != r_q.rxPrev) |=> r_q.rxActivity || !cfg.shutdown;
    endproperty
    a_activity: assert property (p_activity) else $error("activity missed");

endmodule : uarx_readout

// >>> hw/uarx_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module uarx_sync #(
    parameter int unsigned  W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clock,
    input  wire logic         rstN,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] stable
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] held;
    } uarx_sync_s;

    uarx_sync_s s_q;
    uarx_sync_s s_d;

    always_comb begin
        s_d      = s_q;
        s_d.s1   = raw;
        s_d.s2   = s_q.s1;
        s_d.s3   = s_q.s2;
        s_d.held = (s_q.s2 & s_q.s3) | (s_q.held & (s_q.s2 | s_q.s3));
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            s_q <= {RST, RST, RST, RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign stable = s_q.held;

endmodule : uarx_sync

// >>> tb/tb_top.sv
// Self-checking testbench of the receive readout, baud and interrupt block.
`timescale 1ns/1ps
module tb_top;
    import uarx_pkg::*;
    logic        clock;
    logic        rst_n;
    logic        csN;
    logic        sclk;
    logic        din;
    logic        rxPin;
    logic        ctsN;
    uarx_cfg_s   cfg;
    logic        dout;
    logic        irqN;
    logic        txPin;
    logic        rtsN;
    logic [15:0] rsp;
    int          failures;
    int          cmpCount;
    int          bitTime;

    uarx_readout DUT (.clock(clock), .rst_n(rst_n), .csN(csN), .sclk(sclk), .din(din),
        .rxPin(rxPin), .ctsN(ctsN), .cfg(cfg), .dout(dout), .irqN(irqN), .txPin(txPin),
        .rtsN(rtsN));
    uarx_host_model host (.clock(clock), .csN(csN), .sclk(sclk), .din(din), .dout(dout));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic rd(input logic [15:0] exp);
        host.xfer(16'h0000, rsp);
        chk("readout", rsp, exp);
    endtask : rd

    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irqN !== lvl && n < 4000) begin
            @(negedge clock);
            n++;
        end
        chk("irqN", {15'h0, irqN}, {15'h0, lvl});
        if (n >= 4000) stop_test();
    endtask : wait_irq

    task automatic setcfg(input uarx_cfg_s c);
        @(posedge clock) cfg <= c;
        repeat (8) @(posedge clock);
    endtask : setcfg

    task automatic rx_bit(input logic b, input int dur);
        @(posedge clock) rxPin <= b;
        repeat (dur - 1) @(posedge clock);
    endtask : rx_bit

    // A bad stop bit is cut short so the line is idle again when the receiver samples the middle of the false start it then sees.
    task automatic send_char(input logic [7:0] d, input int n, input logic p, input logic stp);
        rx_bit(1'b0, bitTime);
        for (int i = 0; i < n; i++) rx_bit(d[i], bitTime);
        if (cfg.parityEnable) rx_bit(p, bitTime);
        rx_bit(stp, stp ? bitTime : bitTime / 2 + 4);
        rx_bit(1'b1, 2 * bitTime);
    endtask : send_char

    // Samples the transmit line in the middle of start, eight data bits and stop.
    task automatic tx_watch(output logic [9:0] got);
        int n;
        n = 0;
        got = '0;
        while (txPin !== 1'b0 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        repeat (8) @(negedge clock);
        for (int i = 0; i < 10; i++) begin
            got[i] = txPin;
            repeat (16) @(negedge clock);
        end
    endtask : tx_watch

    // ==========================================================
    // Scenarios
    task automatic s_idle;
        rd(16'h4200);
        @(posedge clock) ctsN <= 1'b1;
        repeat (8) @(posedge clock);
        rd(16'h4000);
        wait_irq(1'b1);
    endtask : s_idle

    task automatic s_ready;
        setcfg('{shortWord: 1'b1, availIrqMask: 1'b1, default: '0});
        send_char(8'hff, 7, 1'b0, 1'b1);
        wait_irq(1'b0);
        host.xfer(16'h4000, rsp);
        chk("non-data command", rsp, 16'hc07f);
        rd(16'hc07f);
        wait_irq(1'b1);
    endtask : s_ready

    task automatic s_parity;
        setcfg('{parityEnable: 1'b1, parityIrqMask: 1'b1, default: '0});
        send_char(8'ha5, 8, 1'b1, 1'b1);
        send_char(8'h3c, 8, 1'b0, 1'b1);
        wait_irq(1'b0);
        rd(16'hc1a5);
        wait_irq(1'b1);
        rd(16'hc03c);
        rd(16'h4000);
    endtask : s_parity

    task automatic s_frame;
        setcfg('{actIrqMask: 1'b1, default: '0});
        send_char(8'h81, 8, 1'b0, 1'b0);
        wait_irq(1'b0);
        send_char(8'h42, 8, 1'b0, 1'b1);
        wait_irq(1'b1);
        rd(16'hc081);
        rd(16'hc042);
    endtask : s_frame

    task automatic s_baud;
        logic [3:0] codes [4] = '{4'h0, 4'h3, 4'h8, 4'hb};
        foreach (codes[k]) begin
            setcfg('{baudSelectCode: codes[k], default: '0});
            bitTime = 16 * (codes[k][3] ? 3 << codes[k][2:0] : 1 << codes[k][2:0]);
            send_char(8'h5a ^ {4'h0, codes[k]}, 8, 1'b0, 1'b1);
            rd({8'hc0, 8'h5a ^ {4'h0, codes[k]}});
        end
        bitTime = 16;
    endtask : s_baud

    task automatic s_tx;
        logic [9:0] got;
        setcfg('{txemptyIrqMask: 1'b1, default: '0});
        fork
            host.xfer(16'h805a, rsp);
            tx_watch(got);
        join
        chk("write", rsp, 16'h4000);
        chk("txPin frame", {6'h0, got}, {6'h0, 1'b1, 8'h5a, 1'b0});
        wait_irq(1'b0);
        rd(16'h4000);
        wait_irq(1'b1);
        host.xfer(16'h8600, rsp);
        chk("rtsN", {15'h0, rtsN}, 16'h0000);
        rd(16'h4000);
    endtask : s_tx

    task automatic s_shut;
        setcfg('{shutdown: 1'b1, actIrqMask: 1'b1, default: '0});
        wait_irq(1'b1);
        rx_bit(1'b0, 20);
        rx_bit(1'b1, 20);
        wait_irq(1'b0);
        rd(16'h4400);
        setcfg('{actIrqMask: 1'b1, default: '0});
        wait_irq(1'b1);
    endtask : s_shut

    // ==========================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        rxPin = 1'b1;
        ctsN = 1'b0;
        cfg = '0;
        failures = 0;
        cmpCount = 0;
        bitTime = 16;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (16) @(posedge clock);
        s_idle();
        s_ready();
        s_parity();
        s_frame();
        s_baud();
        s_tx();
        s_shut();
        stop_test();
    end
endmodule : tb_top

// >>> tb/uarx_host_model.sv
// Serial bus master model that runs sixteen-bit words through the readout port.
`timescale 1ns/1ps
module uarx_host_model (
    input  wire logic clock,
    output logic      csN,
    output logic      sclk,
    output logic      din,
    input  wire logic dout
);
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // ==========================================================
    // Word transfer, MSB first, serial clock high for eight clocks and low for sixteen
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        @(posedge clock) csN <= 1'b0;
        repeat (8) @(posedge clock);
        for (int i = 15; i >= 0; i--) begin
            din <= cmd[i];
            repeat (7) @(posedge clock);
            @(negedge clock) rsp[i] = dout;
            @(posedge clock) sclk <= 1'b1;
            repeat (8) @(posedge clock);
            sclk <= 1'b0;
            repeat (8) @(posedge clock);
        end
        csN <= 1'b1;
        // A released data line must not keep showing the last bit.
        din <= ~din;
        repeat (8) @(posedge clock);
    endtask : xfer
endmodule : uarx_host_model
